//--- shared/wcs_map.svh
/*
 Constants of the word command scaling unit: command codes, reply words,
 flag positions, factory settings and the controller's register offsets.
 Assumes 16-bit command and reply words holding four BCD digits.
*/
`ifndef WCS_MAP_SVH
`define WCS_MAP_SVH

// Command words
`define WCS_END_WORD 16'h0000
`define WCS_CMD_MODE_A 16'hC000
`define WCS_PFX_SCALE 8'hC4
`define WCS_SIGN_POS 4'h0
`define WCS_SIGN_NEG 4'hF

// Reply words and comparison flags
`define WCS_OVR_WORD 16'hB000
`define WCS_DISC_WORD 16'hA000
`define WCS_FLAG_PASS 16'h0004
`define WCS_FLAG_OVR 16'h0100
`define WCS_FLAG_DISC 16'h0200

// Mode A parameter digits, zero keeps the current setting
`define WCS_KEEP 4'h0
`define WCS_DI_MEAS 4'h1
`define WCS_DI_CMP 4'h2
`define WCS_IT_BIPOLAR 4'h1
`define WCS_IT_MAX 4'h4

// Scaling limits and factory points, index order X1 X2 Y1 Y2
`define WCS_LIMIT 17'sh0270F
`define WCS_DEF_X1 17'sh00000
`define WCS_DEF_X2 17'sh003E8
`define WCS_DEF_Y1 17'sh00000
`define WCS_DEF_Y2 17'sh003E8
`define WCS_IX_X1 2'h0
`define WCS_IX_X2 2'h1
`define WCS_IX_Y1 2'h2
`define WCS_IX_Y2 2'h3

// Controller register indices
`define WCS_RA_CMD 4'h0
`define WCS_RA_PARAM 4'h1
`define WCS_RA_CTRL 4'h2
`define WCS_RA_STAT 4'h3
`define WCS_RA_IRQ 4'h4
`define WCS_RA_MASK 4'h5
`define WCS_RA_INWORD 4'h6
`define WCS_IRQ_DONE 0
`define WCS_IRQ_TMO 1

`endif

//--- shared/wcs_pkg.sv
/*
 Types shared by both ends of the word command scaling unit.
 Assumes nothing beyond a SystemVerilog tool.
*/
package wcs_pkg;
    typedef logic signed [16:0] wcs_val_t;
    typedef logic [15:0] wcs_word_t;
    typedef enum logic [1:0] {
        WCS_DS_DATA,
        WCS_DS_ECHO_CODE,
        WCS_DS_ECHO_PARAM
    } wcs_dev_state_t;
    typedef enum logic [1:0] {
        WCS_HS_IDLE,
        WCS_HS_CODE,
        WCS_HS_PARAM
    } wcs_host_state_t;
endpackage

//--- shared/wcs_if.sv
/*
 The two I/O words between controller and unit.
 Assumes both ends share one clock; the words are plain registered levels.
*/
`timescale 1ns/1ps
interface wcs_if;
    logic [15:0] out_word;
    logic [15:0] in_word;
    modport dev (input out_word, output in_word);
    modport host (output out_word, input in_word);
endinterface

//--- hdl/wcs_unit.sv
/*
 Device end: command interpreter and two-point scaling stage.
 Assumes sample_i is the input value already in default-scaled counts and
 that the controller's words are synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
`include "wcs_map.svh"

// Function
// - Echo an accepted command code in reply
// - Store parameter, echo it in reply
// - Zero output word restores normal result
// - Decode C40 to C43 as scaling points
// - Lowest code digit gives parameter sign
// - Host sends four BCD digits, max 9999
// - Two-point linear map, limited to 9999
// - Equal input points report overrange word, or overrange flag in comparison
// - Factory points 0, 1000, 0, 1000
// - Default scaling passes counts through unchanged
// - Mode A digits select mode, input type
// - Comparison mode shows result flags, pass 0004
// - Measurement shows BCD result, comparison shows flags
// - Overrange and disconnect give reply words B000/A000, or set reply flags in comparison
module wcs_unit (
    // Clock and control
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Converter side
    input wire logic signed [16:0] sample_i,
    input wire logic overrange_i,
    input wire logic disconnect_i,
    // Settings and result sign
    output logic compare_mode_o,
    output logic [3:0] input_type_o,
    output logic data_neg_o,
    // Controller words
    wcs_if.dev link
);

    function automatic logic bcd_ok(input logic [15:0] w);
        bcd_ok = (w[15:12] <= 4'h9) && (w[11:8] <= 4'h9) &&
                 (w[7:4] <= 4'h9) && (w[3:0] <= 4'h9);
    endfunction

    function automatic logic [13:0] bcd2bin(input logic [15:0] w);
        bcd2bin = 14'(w[15:12]) * 14'h03E8 + 14'(w[11:8]) * 14'h0064 +
                  14'(w[7:4]) * 14'h000A + 14'(w[3:0]);
    endfunction

    function automatic logic [15:0] bin2bcd(input logic [13:0] m);
        bin2bcd = {4'((m / 14'h03E8) % 14'h000A),
                   4'((m / 14'h0064) % 14'h000A),
                   4'((m / 14'h000A) % 14'h000A), 4'(m % 14'h000A)};
    endfunction

    function automatic logic cmd_ok(input logic [15:0] w);
        cmd_ok = (w == `WCS_CMD_MODE_A) ||
                 ((w[15:8] == `WCS_PFX_SCALE) && (w[7:6] == 2'h0) &&
                  ((w[3:0] == `WCS_SIGN_POS) || (w[3:0] == `WCS_SIGN_NEG)));
    endfunction

    // Rounds half away from zero so 400..2000 onto 0..1000 gives 534 at 1254
    function automatic wcs_pkg::wcs_val_t scale(
        input wcs_pkg::wcs_val_t x,
        input wcs_pkg::wcs_val_t x1,
        input wcs_pkg::wcs_val_t x2,
        input wcs_pkg::wcs_val_t y1,
        input wcs_pkg::wcs_val_t y2
    );
        logic signed [17:0] dx;
        logic signed [17:0] dy;
        logic signed [17:0] den;
        logic signed [35:0] num;
        logic [35:0] an;
        logic [17:0] ad;
        logic [36:0] q;
        logic [13:0] mag;
        logic signed [17:0] sum;
        dx = 18'(x) - 18'(x1);
        dy = 18'(y2) - 18'(y1);
        den = 18'(x2) - 18'(x1);
        num = 36'(dx) * 36'(dy);
        an = num[35] ? 36'(-num) : 36'(num);
        ad = den[17] ? 18'(-den) : 18'(den);
        q = ({an, 1'b0} + 37'(ad)) / {18'h00000, ad, 1'b0};
        mag = (q > 37'(`WCS_LIMIT)) ? 14'(`WCS_LIMIT) : 14'(q);
        sum = (num[35] ^ den[17]) ? 18'(y1) - 18'(mag) : 18'(y1) + 18'(mag);
        if (sum > 18'(`WCS_LIMIT)) begin
            scale = `WCS_LIMIT;
        end else if (sum < -18'(`WCS_LIMIT)) begin
            scale = -`WCS_LIMIT;
        end else begin
            scale = 17'(sum);
        end
    endfunction

    wcs_pkg::wcs_dev_state_t st_reg, st_next;
    wcs_pkg::wcs_val_t pts_reg [4];
    wcs_pkg::wcs_val_t pts_next [4];
    logic [15:0] last_reg, last_next;
    logic [15:0] code_reg, code_next;
    logic [15:0] in_reg, in_next;
    logic cmp_reg, cmp_next;
    logic [3:0] type_reg, type_next;
    logic neg_reg, neg_next;

    // Normal reply word from current settings
    wcs_pkg::wcs_val_t y_val;
    logic [15:0] data_word;
    logic data_neg;
    logic [13:0] y_mag;

    always_comb begin
        y_val = scale(sample_i, pts_reg[`WCS_IX_X1], pts_reg[`WCS_IX_X2],
                      pts_reg[`WCS_IX_Y1], pts_reg[`WCS_IX_Y2]);
        y_mag = y_val[16] ? 14'(-y_val) : 14'(y_val);
        data_neg = 1'b0;
        if (cmp_reg) begin
            // Set values stay at factory limits, so in-band means pass
            data_word = `WCS_END_WORD;
            if (overrange_i || pts_reg[`WCS_IX_X1] == pts_reg[`WCS_IX_X2]) begin
                data_word = data_word | `WCS_FLAG_OVR;
            end
            if (disconnect_i) begin
                data_word = data_word | `WCS_FLAG_DISC;
            end
            if (data_word == `WCS_END_WORD) begin
                data_word = `WCS_FLAG_PASS;
            end
        end else if (disconnect_i) begin
            data_word = `WCS_DISC_WORD;
        end else if (overrange_i ||
                     pts_reg[`WCS_IX_X1] == pts_reg[`WCS_IX_X2]) begin
            data_word = `WCS_OVR_WORD;
        end else begin
            data_word = bin2bcd(y_mag);
            data_neg = y_val[16];
        end
    end

    // Command sequencing and settings update
    logic changed;
    logic [13:0] pmag;

    always_comb begin
        st_next = st_reg;
        last_next = link.out_word;
        code_next = code_reg;
        in_next = in_reg;
        cmp_next = cmp_reg;
        type_next = type_reg;
        neg_next = neg_reg;
        for (int i = 0; i < 4; i++) begin
            pts_next[i] = pts_reg[i];
        end
        changed = link.out_word != last_reg;
        pmag = bcd2bin(link.out_word);
        case (st_reg)
            wcs_pkg::WCS_DS_DATA: begin
                in_next = data_word;
                neg_next = data_neg;
                if (changed && cmd_ok(link.out_word)) begin
                    code_next = link.out_word;
                    in_next = link.out_word;
                    neg_next = 1'b0;
                    st_next = wcs_pkg::WCS_DS_ECHO_CODE;
                end
            end
            wcs_pkg::WCS_DS_ECHO_CODE: begin
                // A non-BCD value is no valid parameter and is ignored
                if (changed && bcd_ok(link.out_word)) begin
                    in_next = link.out_word;
                    st_next = wcs_pkg::WCS_DS_ECHO_PARAM;
                    if (code_reg == `WCS_CMD_MODE_A) begin
                        if (link.out_word[15:12] == `WCS_DI_MEAS) begin
                            cmp_next = 1'b0;
                        end else if (link.out_word[15:12] == `WCS_DI_CMP) begin
                            cmp_next = 1'b1;
                        end
                        if (link.out_word[7:4] != `WCS_KEEP &&
                            link.out_word[7:4] <= `WCS_IT_MAX) begin
                            type_next = link.out_word[7:4];
                            // New input type invalidates old scaling
                            if (link.out_word[7:4] != type_reg) begin
                                pts_next[`WCS_IX_X1] = `WCS_DEF_X1;
                                pts_next[`WCS_IX_X2] = `WCS_DEF_X2;
                                pts_next[`WCS_IX_Y1] = `WCS_DEF_Y1;
                                pts_next[`WCS_IX_Y2] = `WCS_DEF_Y2;
                            end
                        end
                    end else if (code_reg[3:0] == `WCS_SIGN_NEG) begin
                        pts_next[code_reg[5:4]] = -17'(pmag);
                    end else begin
                        pts_next[code_reg[5:4]] = 17'(pmag);
                    end
                end
            end
            wcs_pkg::WCS_DS_ECHO_PARAM: begin
                if (changed && link.out_word == `WCS_END_WORD) begin
                    in_next = data_word;
                    neg_next = data_neg;
                    st_next = wcs_pkg::WCS_DS_DATA;
                end else if (changed && cmd_ok(link.out_word)) begin
                    code_next = link.out_word;
                    in_next = link.out_word;
                    st_next = wcs_pkg::WCS_DS_ECHO_CODE;
                end else if (link.out_word == `WCS_END_WORD &&
                             in_reg == `WCS_END_WORD) begin
                    // Zero parameter: the end word repeats it unseen
                    in_next = data_word;
                    neg_next = data_neg;
                    st_next = wcs_pkg::WCS_DS_DATA;
                end
                // Anything else leaves settings and reply alone
            end
            default: begin
                st_next = wcs_pkg::WCS_DS_DATA;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_reg <= wcs_pkg::WCS_DS_DATA;
            last_reg <= `WCS_END_WORD;
            code_reg <= `WCS_END_WORD;
            in_reg <= `WCS_END_WORD;
            cmp_reg <= 1'b0;
            type_reg <= `WCS_IT_BIPOLAR;
            neg_reg <= 1'b0;
            pts_reg[`WCS_IX_X1] <= `WCS_DEF_X1;
            pts_reg[`WCS_IX_X2] <= `WCS_DEF_X2;
            pts_reg[`WCS_IX_Y1] <= `WCS_DEF_Y1;
            pts_reg[`WCS_IX_Y2] <= `WCS_DEF_Y2;
        end else if (ce_i) begin
            st_reg <= st_next;
            last_reg <= last_next;
            code_reg <= code_next;
            in_reg <= in_next;
            cmp_reg <= cmp_next;
            type_reg <= type_next;
            neg_reg <= neg_next;
            for (int i = 0; i < 4; i++) begin
                pts_reg[i] <= pts_next[i];
            end
        end
    end

    assign link.in_word = in_reg;
    assign compare_mode_o = cmp_reg;
    assign input_type_o = type_reg;
    assign data_neg_o = neg_reg;

endmodule // wcs_unit

//--- hdl/wcs_host.sv
/*
 Controller end: runs one code-then-parameter sequence per start and
 reports through its own registers and one interrupt.
 Assumes a plain register port with read data one cycle after the strobe.
*/
`timescale 1ns/1ps
`include "wcs_map.svh"

module wcs_host #(
    parameter int TMO_CYC = 1000
) (
    // Clock and control
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic irq_o,
    // Unit words
    wcs_if.host link
);

    wcs_pkg::wcs_host_state_t st_reg, st_next;
    logic [15:0] cmd_reg, cmd_next;
    logic [15:0] par_reg, par_next;
    logic [15:0] out_reg, out_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [1:0] irq_reg, irq_next;
    logic [1:0] mask_reg, mask_next;
    logic [15:0] rd_reg, rd_next;
    logic int_reg, int_next;
    logic [1:0] ev;

    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        par_next = par_reg;
        out_next = out_reg;
        cnt_next = cnt_reg + 16'h0001;
        mask_next = mask_reg;
        rd_next = rd_reg;
        ev = 2'b00;
        if (wr_i && addr_i == `WCS_RA_CMD) begin
            cmd_next = wdata_i;
        end
        if (wr_i && addr_i == `WCS_RA_PARAM) begin
            par_next = wdata_i;
        end
        if (wr_i && addr_i == `WCS_RA_MASK) begin
            mask_next = wdata_i[1:0];
        end
        case (st_reg)
            wcs_pkg::WCS_HS_IDLE: begin
                if (wr_i && addr_i == `WCS_RA_CTRL && wdata_i[0]) begin
                    out_next = cmd_reg;
                    cnt_next = 16'h0000;
                    st_next = wcs_pkg::WCS_HS_CODE;
                end
            end
            wcs_pkg::WCS_HS_CODE: begin
                if (link.in_word == cmd_reg) begin
                    out_next = par_reg;
                    cnt_next = 16'h0000;
                    st_next = wcs_pkg::WCS_HS_PARAM;
                end
            end
            wcs_pkg::WCS_HS_PARAM: begin
                if (link.in_word == par_reg) begin
                    out_next = `WCS_END_WORD;
                    ev[`WCS_IRQ_DONE] = 1'b1;
                    st_next = wcs_pkg::WCS_HS_IDLE;
                end
            end
            default: begin
                st_next = wcs_pkg::WCS_HS_IDLE;
            end
        endcase
        // Unit silent: end the sequence rather than hang
        if (st_reg != wcs_pkg::WCS_HS_IDLE && st_next == st_reg &&
            cnt_reg == 16'(TMO_CYC)) begin
            out_next = `WCS_END_WORD;
            ev[`WCS_IRQ_TMO] = 1'b1;
            st_next = wcs_pkg::WCS_HS_IDLE;
        end
        // Set wins over a same-cycle clear
        irq_next = irq_reg;
        if (wr_i && addr_i == `WCS_RA_IRQ) begin
            irq_next = irq_reg & ~wdata_i[1:0];
        end
        irq_next = irq_next | ev;
        int_next = |(irq_next & mask_next);
        if (rd_i) begin
            case (addr_i)
                `WCS_RA_CMD: rd_next = cmd_reg;
                `WCS_RA_PARAM: rd_next = par_reg;
                `WCS_RA_STAT: rd_next = {15'h0000,
                    st_reg != wcs_pkg::WCS_HS_IDLE};
                `WCS_RA_IRQ: rd_next = {14'h0000, irq_reg};
                `WCS_RA_MASK: rd_next = {14'h0000, mask_reg};
                `WCS_RA_INWORD: rd_next = link.in_word;
                default: rd_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_reg <= wcs_pkg::WCS_HS_IDLE;
            cmd_reg <= 16'h0000;
            par_reg <= 16'h0000;
            out_reg <= `WCS_END_WORD;
            cnt_reg <= 16'h0000;
            irq_reg <= 2'b00;
            mask_reg <= 2'b00;
            rd_reg <= 16'h0000;
            int_reg <= 1'b0;
        end else if (ce_i) begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            par_reg <= par_next;
            out_reg <= out_next;
            cnt_reg <= cnt_next;
            irq_reg <= irq_next;
            mask_reg <= mask_next;
            rd_reg <= rd_next;
            int_reg <= int_next;
        end
    end

    assign link.out_word = out_reg;
    assign rdata_o = rd_reg;
    assign irq_o = int_reg;

endmodule // wcs_host

//--- verif/wcs_assertions.sv
/*
 Checker on the word link between controller end and unit end.
 Assumes one clock, synchronous active-high reset, words as registered levels.
*/
`timescale 1ns/1ps
`include "wcs_map.svh"

module wcs_assertions #(
    parameter int TMO_CYC = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Link words
    input wire logic [15:0] out_word,
    input wire logic [15:0] in_word
);
    localparam int STALL_MAX = TMO_CYC + 4;
    int stall_cnt;

    function automatic logic is_cmd(input logic [15:0] w);
        return w == `WCS_CMD_MODE_A || (w[15:8] == `WCS_PFX_SCALE &&
            w[7:6] == 2'h0 && (w[3:0] == 4'h0 || w[3:0] == 4'hF));
    endfunction

    function automatic logic is_bcd(input logic [15:0] w);
        return w[15:12] < 4'hA && w[11:8] < 4'hA && w[7:4] < 4'hA &&
            w[3:0] < 4'hA;
    endfunction

    // Age of an unanswered nonzero word, bounds the host's patience
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || out_word == 16'h0000 || !$stable(out_word))
            stall_cnt <= 0;
        else
            stall_cnt <= stall_cnt + 1;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    chk_code_echo: assert property (
        $changed(out_word) && is_cmd(out_word) && !is_cmd(in_word)
        |=> in_word == $past(out_word)) else $error("code not echoed");
    chk_param_echo: assert property (
        is_cmd(in_word) && $changed(out_word) && is_bcd(out_word)
        |=> in_word == $past(out_word)) else $error("param not echoed");
    chk_echo_hold: assert property (
        is_cmd(in_word) && $stable(out_word) |=> $stable(in_word))
        else $error("code echo moved");
    chk_code_next: assert property (
        in_word == out_word && is_cmd(in_word) |=> !is_cmd(out_word))
        else $error("param not sent after echo");
    chk_param_end: assert property (
        is_cmd($past(in_word)) && in_word == out_word && !is_cmd(out_word)
        |=> out_word == 16'h0000) else $error("sequence not ended");
    chk_end_result: assert property (
        $fell(|out_word) |=> !is_cmd(in_word)) else $error("echo after end");
    chk_unknown_code: assert property (
        $changed(out_word) && out_word != 16'h0000 && !is_cmd(out_word) &&
        !is_cmd(in_word) |=> in_word != $past(out_word))
        else $error("unknown code echoed");
    chk_host_wait: assert property (
        stall_cnt <= STALL_MAX) else $error("host waits too long");

    cover property ($changed(out_word) && is_cmd(out_word));
    cover property (stall_cnt == TMO_CYC);
    cover property ($fell(|out_word));
    cover property (in_word == `WCS_OVR_WORD);
endmodule // wcs_assertions

//--- verif/word_command_scaling_unit_test.sv
/*
 Self-checking bench: both ends joined by the link, driven through the
 controller's register port and the unit's converter inputs.
 Assumes package, header and interface are compiled first.
*/
`timescale 1ns/1ps
`include "wcs_map.svh"

module word_command_scaling_unit_test;
    localparam int TMO = 8;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic irq_o;
    logic signed [16:0] sample_i = 17'sh00000;
    logic overrange_i = 1'b0;
    logic disconnect_i = 1'b0;
    logic compare_mode_o;
    logic [3:0] input_type_o;
    logic data_neg_o;
    logic rd_pend = 1'b0;
    logic [18:0] exp_q[$];
    logic [18:0] exp_e;
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 81362;
    int val;

    wcs_if link ();
    wcs_unit i_wcs_unit (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .sample_i(sample_i), .overrange_i(overrange_i),
        .disconnect_i(disconnect_i), .compare_mode_o(compare_mode_o),
        .input_type_o(input_type_o), .data_neg_o(data_neg_o), .link(link));
    wcs_host #(.TMO_CYC(TMO)) i_wcs_host (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .link(link));
    wcs_assertions #(.TMO_CYC(TMO)) i_wcs_assertions (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .out_word(link.out_word), .in_word(link.in_word));

    always #5 clk_sys_i = ~clk_sys_i;

    function automatic logic [15:0] bcd(input int v);
        return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10),
            4'(v % 10)};
    endfunction

    task automatic fail(input string msg);
        num_errors++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic close_out();
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic chk_mode(input logic m, input logic [3:0] t);
        cmp_count++;
        if (compare_mode_o !== m || input_type_o !== t)
            fail("mode outputs wrong");
    endtask

    // Gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        tick(1);
        wr_i <= 1'b0;
        tick(1);
    endtask

    // s: check irq and sign, expected irq, expected sign
    task automatic rd(input logic [3:0] a, input logic [15:0] w,
        input logic [2:0] s);
        exp_q.push_back({s, w});
        addr_i <= a;
        rd_i <= 1'b1;
        tick(1);
        rd_i <= 1'b0;
        tick(1);
    endtask

    task automatic chk_in(input int s, input logic [15:0] w,
        input logic [1:0] f);
        sample_i <= 17'(s);
        tick(3);
        rd(`WCS_RA_INWORD, w, {f[1], 1'b0, f[0]});
    endtask

    task automatic seq(input logic [15:0] c, input logic [15:0] p);
        int n;
        n = 0;
        wr(`WCS_RA_CMD, c);
        wr(`WCS_RA_PARAM, p);
        wr(`WCS_RA_CTRL, 16'h0001);
        do begin
            tick(1);
            #1;
            n++;
        end while (irq_o !== 1'b1 && n < 40);
        tick(1);
        if (n >= 40) begin
            fail("sequence never completed");
            close_out();
        end
        rd(`WCS_RA_STAT, 16'h0000, 3'b000);
        rd(`WCS_RA_IRQ, 16'h0001, 3'b110);
        wr(`WCS_RA_IRQ, 16'h0003);
        rd(`WCS_RA_IRQ, 16'h0000, 3'b100);
    endtask

    always @(posedge clk_sys_i) begin
        if (rd_pend) begin
            exp_e = exp_q.pop_front();
            cmp_count++;
            if (rdata_o !== exp_e[15:0] || (exp_e[18] &&
                {irq_o, data_neg_o} !== exp_e[17:16]))
                fail($sformatf("read %h want %h", rdata_o, exp_e[15:0]));
        end
        rd_pend <= rd_i;
    end

    initial begin
        tick(12);
        rst_i <= 1'b0;
        tick(2);
        chk_mode(1'b0, 4'h1);
        rd(`WCS_RA_IRQ, 16'h0000, 3'b100);
        wr(`WCS_RA_MASK, 16'h0003);
        rd(`WCS_RA_MASK, 16'h0003, 3'b000);
        wr(4'hE, 16'hFFFF);
        rd(4'hE, 16'h0000, 3'b000);
        for (int i = 0; i < 6; i++) begin
            val = 1 + $unsigned($random(seed)) % 9999;
            chk_in(i % 2 ? -val : val, bcd(val), {1'b1, 1'(i % 2)});
        end
        chk_in(400, 16'h0400, 2'b10);
        chk_in(2000, 16'h2000, 2'b10);
        chk_in(5000, 16'h5000, 2'b10);
        chk_in(12000, 16'h9999, 2'b10);
        chk_in(-12000, 16'h9999, 2'b11);
        sample_i <= 17'sd1254;
        seq(16'hC400, 16'h0400);
        seq(16'hC410, 16'h2000);
        seq(16'hC420, 16'h0000);
        chk_in(1254, 16'h0534, 2'b10);
        seq(16'hC430, 16'h1000);
        chk_in(1254, 16'h0534, 2'b10);
        seq(16'hC42F, 16'h1000);
        chk_in(1254, 16'h0068, 2'b10);
        chk_in(400, 16'h1000, 2'b11);
        overrange_i <= 1'b1;
        chk_in(1254, `WCS_OVR_WORD, 2'b00);
        disconnect_i <= 1'b1;
        chk_in(1254, `WCS_DISC_WORD, 2'b00);
        overrange_i <= 1'b0;
        disconnect_i <= 1'b0;
        // Unknown code: host gives up, settings must survive
        wr(`WCS_RA_CMD, 16'hC500);
        wr(`WCS_RA_CTRL, 16'h0001);
        tick(TMO + 12);
        rd(`WCS_RA_IRQ, 16'h0002, 3'b110);
        wr(`WCS_RA_MASK, 16'h0000);
        rd(`WCS_RA_IRQ, 16'h0002, 3'b100);
        wr(`WCS_RA_MASK, 16'h0003);
        wr(`WCS_RA_IRQ, 16'h0002);
        chk_in(1254, 16'h0068, 2'b10);
        seq(16'hC410, 16'h0400);
        chk_in(1254, `WCS_OVR_WORD, 2'b00);
        seq(`WCS_CMD_MODE_A, 16'h2040);
        chk_mode(1'b1, 4'h4);
        chk_in(1254, `WCS_FLAG_PASS, 2'b10);
        overrange_i <= 1'b1;
        chk_in(1254, `WCS_FLAG_OVR, 2'b00);
        disconnect_i <= 1'b1;
        chk_in(1254, 16'h0300, 2'b00);
        overrange_i <= 1'b0;
        disconnect_i <= 1'b0;
        seq(`WCS_CMD_MODE_A, 16'h1000);
        chk_mode(1'b0, 4'h4);
        chk_in(1254, 16'h1254, 2'b10);
        // Clock enable low must freeze the reply word
        ce_i <= 1'b0;
        sample_i <= 17'sh00190;
        tick(4);
        ce_i <= 1'b1;
        rd(`WCS_RA_INWORD, 16'h1254, 3'b100);
        chk_in(400, 16'h0400, 2'b10);
        close_out();
    end

    initial begin
        tick(20000);
        fail("run did not finish");
        close_out();
    end
endmodule // word_command_scaling_unit_test
